// ---- hdl/fes_ctrl.v ----
/*
  Host controller for a byte-wide flash: erase-all sequence, status
  polling, full status check, status clear and return to read array,
  ordered by software through a classic Wishbone slave.
  Assumes synchronous pins on clk_i and a bench that resolves dq.
*/
`default_nettype none
`include "fes_consts.vh"

module fes_ctrl #(
  parameter ADDR_W = 16,
  parameter [7:0] SETUP_CYC = `FES_SETUP_CYC,
  parameter [7:0] PULSE_CYC = `FES_PULSE_CYC,
  parameter [7:0] RECOV_CYC = `FES_RECOV_CYC
) (
  input wire clk_i,                 // system clock
  input wire rst_i,                 // synchronous reset
  input wire wb_cyc_i,              // bus cycle
  input wire wb_stb_i,              // strobe
  input wire wb_we_i,               // write
  input wire [3:0] wb_adr_i,        // byte address
  input wire [3:0] wb_sel_i,        // byte lanes
  input wire [31:0] wb_dat_i,       // write data
  output reg [31:0] wb_dat_o,       // read data
  output reg wb_ack_o,              // acknowledge
  output wire [ADDR_W-1:0] fl_a_o,  // flash address
  input wire [7:0] fl_dq_i,         // flash data in
  output wire [7:0] fl_dq_o,        // flash data out
  output wire fl_dq_oe_n_o,         // low while driving
  output wire fl_ce_n_o,            // chip enable
  output wire fl_oe_n_o,            // output enable
  output wire fl_we_n_o             // write enable
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_CLR = 7'h02;
  localparam [6:0] S_ERA = 7'h04;
  localparam [6:0] S_CONF = 7'h08;
  localparam [6:0] S_POLL = 7'h10;
  localparam [6:0] S_ARRAY = 7'h20;
  localparam [6:0] S_WAIT = 7'h40;

  // ***********************************************************
  // state
  // ***********************************************************
  reg [6:0] state_reg, state_next;
  reg [6:0] after_reg, after_next;
  reg launch_reg, launch_next;
  reg op_wr_reg, op_wr_next;
  reg [7:0] op_data_reg, op_data_next;
  reg eval_reg, eval_next;
  reg [7:0] fstat_reg, fstat_next;
  reg erase_err_reg, erase_err_next;
  reg seq_err_reg, seq_err_next;
  reg vpp_low_reg, vpp_low_next;
  reg pend_reg, pend_next;
  reg done_reg, done_next;
  reg [7:0] cnt_reg, cnt_next;
  reg each_reg;
  reg [7:0] clr_code_reg;

  wire [7:0] rd_byte;
  wire op_done;
  wire st_ready, st_erase_err, st_seq_err, st_vpp_low, st_any_err;

  // ***********************************************************
  // bus decode
  // ***********************************************************
  function is_off;
    input [3:0] adr;
    input [3:0] off;
    begin
      is_off = (adr[3:2] == off[3:2]);
    end
  endfunction

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire ctrl_wr = bus_wr & wb_sel_i[0] & is_off(wb_adr_i, `FES_OFF_CTRL);
  wire busy = (state_reg != S_IDLE);
  wire cmd_ok = ctrl_wr & ~busy;
  wire cmd_erase = cmd_ok & wb_dat_i[`FES_CTRL_ERASE];
  wire cmd_array = cmd_ok & wb_dat_i[`FES_CTRL_ARRAY];
  wire cmd_check = cmd_ok & wb_dat_i[`FES_CTRL_CHECK];
  wire cmd_clear = cmd_ok & wb_dat_i[`FES_CTRL_CLEAR];

  // ***********************************************************
  // sub-blocks
  // ***********************************************************
  fes_strobe #(
    .SETUP_CYC(SETUP_CYC),
    .PULSE_CYC(PULSE_CYC),
    .RECOV_CYC(RECOV_CYC)
  ) u_fes_strobe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(launch_reg),
    .wr_i(op_wr_reg),
    .data_i(op_data_reg),
    .dq_i(fl_dq_i),
    .dq_o(fl_dq_o),
    .dq_oe_n_o(fl_dq_oe_n_o),
    .ce_n_o(fl_ce_n_o),
    .oe_n_o(fl_oe_n_o),
    .we_n_o(fl_we_n_o),
    .rd_data_o(rd_byte),
    .done_o(op_done)
  );

  fes_status_eval u_fes_status_eval (
    .status_i(rd_byte),
    .ready_o(st_ready),
    .erase_err_o(st_erase_err),
    .seq_err_o(st_seq_err),
    .vpp_low_o(st_vpp_low),
    .any_err_o(st_any_err)
  );

  // address is a don't-care for every cycle issued here
  assign fl_a_o = {ADDR_W{1'b0}};

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always @* begin
    state_next = state_reg;
    after_next = after_reg;
    launch_next = 1'b0;
    op_wr_next = op_wr_reg;
    op_data_next = op_data_reg;
    eval_next = eval_reg;
    fstat_next = fstat_reg;
    erase_err_next = erase_err_reg;
    seq_err_next = seq_err_reg;
    vpp_low_next = vpp_low_reg;
    pend_next = pend_reg;
    done_next = done_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      S_IDLE: begin
        if (cmd_ok) begin
          done_next = 1'b0;
        end
        if (cmd_erase) begin
          eval_next = each_reg;
          launch_next = 1'b1;
          if (pend_reg) begin
            state_next = S_CLR;
            after_next = S_ERA;
            op_wr_next = 1'b1;
            op_data_next = clr_code_reg;
          end else begin
            state_next = S_ERA;
            op_wr_next = 1'b1;
            op_data_next = `FES_CMD_ERASE_ALL;
          end
        end else if (cmd_check) begin
          state_next = S_POLL;
          eval_next = 1'b1;
          launch_next = 1'b1;
          op_wr_next = 1'b0;
        end else if (cmd_clear) begin
          state_next = S_CLR;
          after_next = S_IDLE;
          launch_next = 1'b1;
          op_wr_next = 1'b1;
          op_data_next = clr_code_reg;
        end else if (cmd_array) begin
          state_next = S_ARRAY;
          launch_next = 1'b1;
          op_wr_next = 1'b1;
          op_data_next = `FES_CMD_READ_ARRAY;
        end
      end
      S_CLR: begin
        if (op_done) begin
          pend_next = 1'b0;
          erase_err_next = 1'b0;
          seq_err_next = 1'b0;
          vpp_low_next = 1'b0;
          if (after_reg == S_ERA) begin
            state_next = S_ERA;
            launch_next = 1'b1;
            op_data_next = `FES_CMD_ERASE_ALL;
          end else begin
            state_next = S_IDLE;
            done_next = 1'b1;
          end
        end
      end
      S_ERA: begin
        if (op_done) begin
          state_next = S_CONF;
          launch_next = 1'b1;
          op_data_next = `FES_CMD_CONFIRM;
        end
      end
      S_CONF: begin
        if (op_done) begin
          state_next = S_POLL;
          launch_next = 1'b1;
          op_wr_next = 1'b0;
          cnt_next = cnt_reg + 8'h01;
        end
      end
      S_POLL: begin
        if (op_done) begin
          fstat_next = rd_byte;
          if (st_ready) begin
            state_next = S_IDLE;
            done_next = 1'b1;
            if (eval_reg) begin
              erase_err_next = st_erase_err;
              seq_err_next = st_seq_err;
              vpp_low_next = st_vpp_low;
              pend_next = st_any_err;
              cnt_next = 8'h00;
            end
          end else begin
            launch_next = 1'b1;
          end
        end
      end
      S_ARRAY: begin
        if (op_done) begin
          state_next = S_IDLE;
          done_next = 1'b1;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      after_reg <= S_IDLE;
      launch_reg <= 1'b0;
      op_wr_reg <= 1'b0;
      op_data_reg <= 8'h00;
      eval_reg <= 1'b0;
      fstat_reg <= 8'h00;
      erase_err_reg <= 1'b0;
      seq_err_reg <= 1'b0;
      vpp_low_reg <= 1'b0;
      pend_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      after_reg <= after_next;
      launch_reg <= launch_next;
      op_wr_reg <= op_wr_next;
      op_data_reg <= op_data_next;
      eval_reg <= eval_next;
      fstat_reg <= fstat_next;
      erase_err_reg <= erase_err_next;
      seq_err_reg <= seq_err_next;
      vpp_low_reg <= vpp_low_next;
      pend_reg <= pend_next;
      done_reg <= done_next;
      cnt_reg <= cnt_next;
    end
  end

  // ***********************************************************
  // config register
  // ***********************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      each_reg <= `FES_CFG_EACH_RST;
      clr_code_reg <= `FES_CFG_CODE_RST;
    end else if (bus_wr & is_off(wb_adr_i, `FES_OFF_CFG)) begin
      if (wb_sel_i[0]) begin
        each_reg <= wb_dat_i[`FES_CFG_EACH];
      end
      if (wb_sel_i[1]) begin
        clr_code_reg <= wb_dat_i[`FES_CFG_CODE_LSB +: 8];
      end
    end
  end

  // ***********************************************************
  // bus answer
  // ***********************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req & ~wb_we_i) begin
        if (is_off(wb_adr_i, `FES_OFF_CFG)) begin
          wb_dat_o[`FES_CFG_EACH] <= each_reg;
          wb_dat_o[`FES_CFG_CODE_LSB +: 8] <= clr_code_reg;
        end else if (is_off(wb_adr_i, `FES_OFF_STAT)) begin
          wb_dat_o[`FES_ST_BUSY] <= busy;
          wb_dat_o[`FES_ST_DONE] <= done_reg;
          wb_dat_o[`FES_ST_ERASE_ERR] <= erase_err_reg;
          wb_dat_o[`FES_ST_SEQ_ERR] <= seq_err_reg;
          wb_dat_o[`FES_ST_VPP_LOW] <= vpp_low_reg;
          wb_dat_o[`FES_ST_PEND] <= pend_reg;
          wb_dat_o[`FES_ST_CNT_LSB +: 8] <= cnt_reg;
        end else if (is_off(wb_adr_i, `FES_OFF_FSTAT)) begin
          wb_dat_o[7:0] <= fstat_reg;
        end
      end
    end
  end

endmodule // fes_ctrl
`default_nettype wire

// ---- hdl/fes_consts.vh ----
/*
  Constants of the erase-all / status-check flash controller: register
  offsets, field positions, reset values, command codes, timing counts.
  Assumes a 250 MHz system clock and a byte-wide asynchronous flash.
*/
`ifndef FES_CONSTS_VH
`define FES_CONSTS_VH

// ***********************************************************
// register offsets (byte addresses)
// ***********************************************************
`define FES_OFF_CTRL 4'h0
`define FES_OFF_CFG 4'h4
`define FES_OFF_STAT 4'h8
`define FES_OFF_FSTAT 4'hC

// ***********************************************************
// control and config fields
// ***********************************************************
`define FES_CTRL_ERASE 0
`define FES_CTRL_ARRAY 1
`define FES_CTRL_CHECK 2
`define FES_CTRL_CLEAR 3
`define FES_CFG_EACH 0
`define FES_CFG_CODE_LSB 8
`define FES_CFG_EACH_RST 1'h1
`define FES_CFG_CODE_RST 8'h00

// ***********************************************************
// status fields
// ***********************************************************
`define FES_ST_BUSY 0
`define FES_ST_DONE 1
`define FES_ST_ERASE_ERR 2
`define FES_ST_SEQ_ERR 3
`define FES_ST_VPP_LOW 4
`define FES_ST_PEND 5
`define FES_ST_CNT_LSB 8

// ***********************************************************
// flash status byte bits and command codes
// ***********************************************************
`define FES_FS_READY 7
`define FES_FS_ERR_HI 5
`define FES_FS_ERR_LO 4
`define FES_FS_VPP 3
`define FES_CMD_ERASE_ALL 8'hA7
`define FES_CMD_CONFIRM 8'hD0
`define FES_CMD_READ_ARRAY 8'hFF

// ***********************************************************
// timing
// ***********************************************************
`define FES_CLK_PERIOD_NS 4
`define FES_SETUP_NS 20
`define FES_PULSE_NS 120
`define FES_RECOV_NS 40
// cycle counts: the ns figures above rounded up to whole clocks
`define FES_SETUP_CYC 8'h05
`define FES_PULSE_CYC 8'h1E
`define FES_RECOV_CYC 8'h0A

`endif

// ---- hdl/fes_status_eval.v ----
/*
  Decoder of the flash status byte into ready and error flags.
  Assumes the byte was captured from a completed status read.
*/
`default_nettype none
`include "fes_consts.vh"

module fes_status_eval (
  input wire [7:0] status_i, // captured status byte
  output wire ready_o,       // state machine ready
  output wire erase_err_o,   // erase failed
  output wire seq_err_o,     // invalid command sequence
  output wire vpp_low_o,     // programming supply low
  output wire any_err_o      // some error bit set
);

  assign ready_o = status_i[`FES_FS_READY];
  assign erase_err_o = status_i[`FES_FS_ERR_HI] |
                       status_i[`FES_FS_ERR_LO];
  assign seq_err_o = status_i[`FES_FS_ERR_HI] &
                     status_i[`FES_FS_ERR_LO];
  assign vpp_low_o = status_i[`FES_FS_VPP];
  assign any_err_o = erase_err_o | vpp_low_o;

endmodule // fes_status_eval
`default_nettype wire

// ---- hdl/fes_strobe.v ----
/*
  One asynchronous flash bus cycle, write or read, with timed strobes.
  Assumes start_i is a one-cycle pulse given only while idle.
*/
`default_nettype none
`include "fes_consts.vh"

module fes_strobe #(
  parameter [7:0] SETUP_CYC = `FES_SETUP_CYC,
  parameter [7:0] PULSE_CYC = `FES_PULSE_CYC,
  parameter [7:0] RECOV_CYC = `FES_RECOV_CYC
) (
  input wire clk_i,           // system clock
  input wire rst_i,           // synchronous reset
  input wire start_i,         // begin a cycle
  input wire wr_i,            // 1 write, 0 read
  input wire [7:0] data_i,    // write byte
  input wire [7:0] dq_i,      // flash data in
  output reg [7:0] dq_o,      // flash data out
  output reg dq_oe_n_o,       // low while driving
  output reg ce_n_o,          // chip enable
  output reg oe_n_o,          // output enable
  output reg we_n_o,          // write enable
  output reg [7:0] rd_data_o, // sampled byte
  output reg done_o           // cycle finished
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SETUP = 4'h2;
  localparam [3:0] S_PULSE = 4'h4;
  localparam [3:0] S_RECOV = 4'h8;

  reg [3:0] state_reg;
  reg [7:0] cnt_reg;
  reg wr_reg;

  // ***********************************************************
  // strobe sequencer
  // ***********************************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      dq_o <= 8'h00;
      dq_oe_n_o <= 1'b1;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      rd_data_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      cnt_reg <= cnt_reg + 8'h01;
      case (state_reg)
        S_IDLE: begin
          cnt_reg <= 8'h00;
          if (start_i) begin
            state_reg <= S_SETUP;
            wr_reg <= wr_i;
            dq_o <= data_i;
            dq_oe_n_o <= ~wr_i;
            ce_n_o <= 1'b0;
          end
        end
        S_SETUP: begin
          if (cnt_reg + 8'h01 >= SETUP_CYC) begin
            state_reg <= S_PULSE;
            cnt_reg <= 8'h00;
            we_n_o <= ~wr_reg;
            oe_n_o <= wr_reg;
          end
        end
        S_PULSE: begin
          if (cnt_reg + 8'h01 >= PULSE_CYC) begin
            state_reg <= S_RECOV;
            cnt_reg <= 8'h00;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            ce_n_o <= 1'b1;
            if (!wr_reg) begin
              rd_data_o <= dq_i;
            end
          end
        end
        S_RECOV: begin
          dq_oe_n_o <= 1'b1;
          if (cnt_reg + 8'h01 >= RECOV_CYC) begin
            state_reg <= S_IDLE;
            done_o <= 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // fes_strobe
`default_nettype wire

// ---- verification/fes_flash_model.sv ----
/*
  Behavioural flash status side: command decode, erase timer, status byte.
  Assumes the strobes change only after rising edges of clk_i.
*/
`default_nettype none
module fes_flash_model #(
  parameter logic [7:0] CLR_CODE = 8'h50,
  parameter int ERASE_CYC = 20
) (
  input wire logic clk_i,       // clock
  input wire logic ce_n_i,      // chip enable
  input wire logic oe_n_i,      // output enable
  input wire logic we_n_i,      // write enable
  input wire logic [7:0] dq_i,  // resolved data wire
  input wire logic fail_i,      // erase ends in error
  input wire logic vpp_i,       // supply low at erase end
  input wire logic seq_i,       // sequence error at erase end
  output logic [7:0] dq_o,      // data driven by the flash
  output logic [23:0] hist_o,   // last three commands
  output logic array_o          // read array mode
);
  // ********************************
  // command decode and status
  // ********************************
  logic [7:0] cstat_reg = 8'h80;
  logic [7:0] shown_reg = 8'h80;
  logic [7:0] last_reg = 8'h00;
  logic we_q = 1'b1;
  logic ce_q = 1'b1;
  logic oe_q = 1'b1;
  logic armed_reg = 1'b0;
  int busy_cnt = 0;
  initial hist_o = 24'h0;
  initial array_o = 1'b1;
  always @(posedge clk_i) begin
    we_q <= we_n_i;
    ce_q <= ce_n_i;
    oe_q <= oe_n_i;
    if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) begin
        cstat_reg[7] <= 1'b1;
        if (fail_i) cstat_reg[5] <= 1'b1;
        if (seq_i) cstat_reg[5:4] <= 2'b11;
        if (vpp_i) cstat_reg[3] <= 1'b1;
      end
    end
    if (we_n_i && !we_q && !ce_q) begin
      hist_o <= {hist_o[15:0], dq_i};
      array_o <= (dq_i == 8'hFF);
      if (armed_reg) begin
        armed_reg <= 1'b0;
        if (dq_i == 8'hD0) begin
          cstat_reg[7] <= 1'b0;
          busy_cnt <= ERASE_CYC;
        end else
          cstat_reg[5:4] <= 2'b11;
      end else if (dq_i == 8'hA7)
        armed_reg <= 1'b1;
      else if (dq_i == CLR_CODE)
        cstat_reg[5:3] <= 3'b000;
    end
    if (!ce_n_i && !oe_n_i && (ce_q || oe_q))
      shown_reg <= cstat_reg;
    if (!ce_n_i && !oe_n_i)
      last_reg <= dq_o;
  end
  // released bus shows the inverse of the last byte
  assign dq_o = (!ce_n_i && !oe_n_i) ? (array_o ? 8'hFF : shown_reg)
              : ~last_reg;
endmodule // fes_flash_model
`default_nettype wire

// ---- verification/fes_ctrl_checker.sv ----
/*
  Checker of the flash strobes and bus answer of fes_ctrl.
  Bound to fes_ctrl; sees only its ports.
*/
`default_nettype none
module fes_ctrl_checker #(
  parameter ADDR_W = 16
) (
  input wire logic clk_i,               // clock
  input wire logic rst_i,               // reset
  input wire logic wb_cyc_i,            // cycle
  input wire logic wb_stb_i,            // strobe
  input wire logic wb_we_i,             // write
  input wire logic [3:0] wb_adr_i,      // address
  input wire logic [3:0] wb_sel_i,      // lanes
  input wire logic [31:0] wb_dat_i,     // write data
  input wire logic [31:0] wb_dat_o,     // read data
  input wire logic wb_ack_o,            // acknowledge
  input wire logic [ADDR_W-1:0] fl_a_o, // flash address
  input wire logic [7:0] fl_dq_i,       // flash data in
  input wire logic [7:0] fl_dq_o,       // flash data out
  input wire logic fl_dq_oe_n_o,        // driving when low
  input wire logic fl_ce_n_o,           // chip enable
  input wire logic fl_oe_n_o,           // output enable
  input wire logic fl_we_n_o            // write enable
);
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp)
    else $error("no ack one cycle after request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_excl; !(!fl_we_n_o && !fl_oe_n_o); endproperty
  a_excl: assert property (p_excl)
    else $error("write and output enable both low");
  property p_we_ce; !fl_we_n_o |-> !fl_ce_n_o && !fl_dq_oe_n_o; endproperty
  a_we_ce: assert property (p_we_ce)
    else $error("write pulse without chip enable or data");
  property p_we_hold; !fl_we_n_o && !$past(fl_we_n_o) |-> $stable(fl_dq_o);
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("write byte moved during pulse");
  property p_release; $rose(fl_we_n_o) |=> fl_dq_oe_n_o; endproperty
  a_release: assert property (p_release)
    else $error("data not released after write");
  property p_read_float; !fl_oe_n_o |-> fl_dq_oe_n_o && !fl_ce_n_o;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("driving data during read");
  property p_toggle; $rose(fl_oe_n_o) |-> $rose(fl_ce_n_o); endproperty
  a_toggle: assert property (p_toggle)
    else $error("chip enable not toggled after read");
  property p_addr; fl_a_o == '0; endproperty
  a_addr: assert property (p_addr)
    else $error("flash address not zero");
endmodule // fes_ctrl_checker
bind fes_ctrl fes_ctrl_checker #(.ADDR_W(ADDR_W)) u_fes_ctrl_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fl_a_o(fl_a_o), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o),
  .fl_dq_oe_n_o(fl_dq_oe_n_o), .fl_ce_n_o(fl_ce_n_o),
  .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));
`default_nettype wire

// ---- verification/fes_ctrl_tb_top.sv ----
/*
  Testbench of fes_ctrl: Wishbone master tasks and erase scenarios.
  Assumes the flash model and the bound checker are compiled first.
*/
`default_nettype none
module fes_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // design, model and wiring
  // ********************************
  localparam logic [7:0] CLR = 8'h50;
  logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic fail = 1'b0, vpp = 1'b0, seq = 1'b0, arr, ack, dq_oe_n;
  logic ce_n, oe_n, we_n;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] fdq, mdq;
  wire logic [7:0] dq_w;
  logic [23:0] hist;
  int bad_count = 0, num_checks = 0, cycles = 0;
  assign dq_w = dq_oe_n ? mdq : fdq;
  fes_ctrl #(.SETUP_CYC(8'h01), .PULSE_CYC(8'h02), .RECOV_CYC(8'h01))
    u_fes_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fl_a_o(),
    .fl_dq_i(dq_w), .fl_dq_o(fdq), .fl_dq_oe_n_o(dq_oe_n),
    .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n));
  fes_flash_model #(.CLR_CODE(CLR)) u_fes_flash_model (.clk_i(clk_i),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_w),
    .fail_i(fail), .vpp_i(vpp), .seq_i(seq), .dq_o(mdq),
    .hist_o(hist), .array_o(arr));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ********************************
  // shared tasks
  // ********************************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      end_of_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask
  task automatic run(input logic [31:0] cmd);
    logic [31:0] s;
    wr(4'h0, cmd);
    do wb(1'b0, 4'h8, 32'h0, s); while (s[0] !== 1'b0);
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_regs;
    rd_chk(4'h4, 32'hFFFFFFFF, 32'h1);
    rd_chk(4'h8, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
    rd_chk(4'h0, 32'hFFFFFFFF, 32'h0);
    wr(4'h8, 32'hFFFFFFFF);
    rd_chk(4'h8, 32'hFFFFFFFF, 32'h0);
    wr(4'h4, {16'h0, CLR, 8'h01});
    rd_chk(4'h4, 32'hFFFFFFFF, {16'h0, CLR, 8'h01});
  endtask
  task automatic t_fail;
    fail <= 1'b1;
    run(32'h1);
    rd_chk(4'h8, 32'h3F, 32'h26);
    rd_chk(4'hC, 32'hFF, 32'hA0);
    fail <= 1'b0;
    run(32'h1);
    chk({8'h0, hist}, {8'h0, CLR, 8'hA7, 8'hD0});
    rd_chk(4'h8, 32'h3F, 32'h02);
    rd_chk(4'hC, 32'hFF, 32'h80);
  endtask
  task automatic t_flags;
    vpp <= 1'b1;
    run(32'h1);
    rd_chk(4'h8, 32'h3F, 32'h32);
    rd_chk(4'hC, 32'hFF, 32'h88);
    vpp <= 1'b0;
    seq <= 1'b1;
    run(32'h1);
    rd_chk(4'h8, 32'h3F, 32'h2E);
    seq <= 1'b0;
  endtask
  task automatic t_batch;
    wr(4'h4, {16'h0, CLR, 8'h00});
    fail <= 1'b1;
    run(32'h1);
    run(32'h1);
    rd_chk(4'h8, 32'hFF3F, 32'h0202);
    run(32'h4);
    rd_chk(4'h8, 32'h3F, 32'h26);
    fail <= 1'b0;
  endtask
  task automatic t_array;
    run(32'h8);
    chk({24'h0, hist[7:0]}, {24'h0, CLR});
    rd_chk(4'h8, 32'h3F, 32'h02);
    run(32'h2);
    chk({24'h0, hist[7:0]}, 32'hFF);
    chk({31'h0, arr}, 32'h1);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_fail;
    t_flags;
    t_batch;
    t_array;
    end_of_test;
  end
endmodule // fes_ctrl_tb_top
`default_nettype wire
